// ---- ccq_can_node.sv ----
// far-side can node model: frame source and query answerer
`timescale 1ns/10ps
module ccq_can_node
    import ccq_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tx_req_i,
    input  wire logic rx_rdy_i,
    output ccq_frame_t rx_o,
    output logic       tx_done_o
);
    int cnt;
    // answer delay in cycles, raised by the bench for a slow node
    int dly = 2;

    initial rx_o = '0;

    // ------------------------------------------------------------
    // query transmission completes dly+1 cycles after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_req_i) begin
            cnt       <= 0;
            tx_done_o <= 1'b0;
        end else begin
            cnt       <= cnt + 1;
            tx_done_o <= (cnt == dly);
        end
    end

    // frame is held until the edge that samples rx_rdy high
    task automatic send(input logic [1:0] i, input logic [3:0] l, input logic [7:0] c, v);
        @(posedge clk_i);
        rx_o <= {1'b1, i, l, c, v};
        @(posedge clk_i);
        while (rx_rdy_i !== 1'b1) @(posedge clk_i);
        // released lines show the inverse, never a stale copy
        rx_o <= {1'b0, ~i, ~l, ~c, ~v};
    endtask : send
endmodule : ccq_can_node

// ---- ccq_core.sv ----
// can consume and query/response transaction handler with wishbone registers
//
// Contract
// RL1: with consistency check on, data is copied only after all frames arrived and passed checks.
// RL2: with consistency check off, each good frame updates data at once and the timeout is zero.
// RL3: a transaction times out when no valid reception comes within the timeout; zero disables.
// RL4: on subnetwork offline the input data is cleared or frozen as the offline option says.
// RL5: the reception counter byte increments on each reception when enabled.
// RL6: the status byte is rewritten whenever the transaction state changes, when enabled.
// RL7: status bit 0 is one while the transaction is timed out.
// RL8: status bit 1 is one on a data error: range, size or constant byte mismatch.
// RL9: status bit 2 is one until first execution, and bits 3 to 7 read zero.
// RL10: in query mode the block sends the query and expects a response within the timeout.
// RL11: the timeout bounds the wait for a response and flags an error when it expires.
// RL12: the configurer keeps the query timeout below the query update interval.
// RL13: a query has the produce options except remote-request trigger; a response consumes.
// RL14: a cyclic query is sent every update interval in milliseconds.
// RL15: the transmission counter byte increments on each completed query when enabled.
// RL16: the timeout runs from the last reception or query sent, on a millisecond tick.
// RL17: both counter bytes wrap from 255 to 0.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module ccq_core
    import ccq_pkg::*;
#(
    parameter int TICK_CYC = MS_CYCLES,
    parameter int FRAMES   = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire ccq_frame_t  rx_i,
    output logic             rx_rdy_o,
    input  wire logic        offline_i,
    output logic             tx_req_o,
    input  wire logic        tx_done_i,
    output logic             irq_o,
    output logic      [7:0]  tstate_o
);

    localparam logic [3:0] ALL  = 4'((1 << FRAMES) - 1);
    localparam logic [1:0] LAST = 2'(FRAMES - 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : bmerge

    // nonzero values under the least accepted figure are raised to it
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo);
        return (v != 16'h0000 && v < lo) ? lo : v;
    endfunction : clamp

    function automatic logic [7:0] pd_at(input logic [7:0] base, input logic [1:0] idx);
        return 8'(base + {6'h00, idx});
    endfunction : pd_at

    ccq_state_t  s;
    ccq_state_t  n;
    logic [7:0]  pd_rdata;
    logic        fr_ok;
    logic        fr_err;
    logic [15:0] tmo_eff;
    logic [7:0]  imm_addr;

    ccq_pd_mem #(.AW(8)) u_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .wr_i    (s.mw),
        .raddr_i (s.pda),
        .rdata_o (pd_rdata)
    );

    assign fr_ok    = rx_i.vld && s.rx_rdy && (int'(rx_i.idx) < FRAMES);
    // RL8 three checks
    assign fr_err   = (rx_i.len != s.chk[3:0]) || (rx_i.cbyte != s.chk[15:8])
                   || (rx_i.val > s.chk[23:16]);
    // RL2 timeout zero
    assign tmo_eff  = s.ctrl.cons_en ? s.tmo : 16'h0000;
    assign imm_addr = pd_at(s.addrs[7:0], rx_i.idx);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic rx_evt;
        logic qfire;
        rx_evt = 1'b0;
        qfire  = 1'b0;
        n      = s;
        n.ack  = 1'b0;
        n.tick = 1'b0;
        n.mw   = '0;
        n.ctrl.shot = 1'b0;

        // RL16 millisecond tick
        if (s.div == 16'(TICK_CYC - 1)) begin
            n.div  = 16'h0000;
            n.tick = 1'b1;
        end else begin
            n.div = s.div + 16'h0001;
        end

        // wishbone slave, one wait state, unmapped reads give zero
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            n.ack  = 1'b1;
            n.rdat = 32'h0000_0000;
            if (wb_we_i) begin
                case (wb_adr_i)
                    R_CTRL: n.ctrl = ccq_ctrl_t'(8'(bmerge({24'h0, s.ctrl}, wb_dat_i,
                                                             wb_sel_i)));
                    // RL3 accepted range
                    R_TMO:  n.tmo = clamp(16'(bmerge({16'h0, s.tmo}, wb_dat_i, wb_sel_i)),
                                          TMO_MIN_MS);
                    // RL14 accepted range
                    R_UPD:  n.upd = clamp(16'(bmerge({16'h0, s.upd}, wb_dat_i, wb_sel_i)),
                                          UPD_MIN_MS);
                    R_ADDR: n.addrs = bmerge(s.addrs, wb_dat_i, wb_sel_i);
                    R_CHK:  n.chk = 24'(bmerge({8'h0, s.chk}, wb_dat_i, wb_sel_i));
                    R_MASK: n.mask = 4'(bmerge({28'h0, s.mask}, wb_dat_i, wb_sel_i));
                    R_PDA:  n.pda = 8'(bmerge({24'h0, s.pda}, wb_dat_i, wb_sel_i));
                    default: ;
                endcase
            end else begin
                case (wb_adr_i)
                    R_CTRL:   n.rdat = {24'h0, s.ctrl};
                    R_TMO:    n.rdat = {16'h0, s.tmo};
                    R_UPD:    n.rdat = {16'h0, s.upd};
                    R_ADDR:   n.rdat = s.addrs;
                    R_CHK:    n.rdat = {8'h0, s.chk};
                    R_TSTATE: n.rdat = {24'h0, s.tstate};
                    R_IRQ: begin
                        n.rdat = {28'h0, s.irq};
                        n.irq  = 4'h0;
                    end
                    R_MASK:   n.rdat = {28'h0, s.mask};
                    R_PDA:    n.rdat = {24'h0, s.pda};
                    R_PDD:    n.rdat = {24'h0, pd_rdata};
                    R_CNT:    n.rdat = {16'h0, s.txcnt, s.rxcnt};
                    default:  n.rdat = 32'h0000_0000;
                endcase
            end
        end

        // RL4 clear only when the option asks for it; freeze needs no action
        n.offl_q = offline_i;
        if (offline_i && !s.offl_q && s.ctrl.offl_clr) begin
            n.clr_pend = 1'b1;
        end

        // RL3 RL11 timeout countdown
        if (s.tick && s.armed && tmo_eff != 16'h0000) begin
            if (s.timer <= 16'h0001) begin
                n.armed           = 1'b0;
                n.tstate[ST_TMO]  = 1'b1;
                n.irq[IRQ_TMO]    = 1'b1;
            end else begin
                n.timer = s.timer - 16'h0001;
            end
        end

        // RL10 RL15 query sent; RL16 wait restarts from here
        if (s.tx_req && tx_done_i) begin
            n.tx_req       = 1'b0;
            n.irq[IRQ_TX]  = 1'b1;
            if (s.ctrl.txcnt_en) begin
                n.txcnt     = s.txcnt + 8'h01;
                n.txc_dirty = 1'b1;
            end
            if (tmo_eff != 16'h0000) begin
                n.timer = tmo_eff;
                n.armed = 1'b1;
            end
        end

        // RL14 cyclic query; RL13 single shot stands in for the other produce triggers
        if (s.ctrl.qr_en && s.ctrl.cyc_en && s.upd != 16'h0000 && s.tick) begin
            if (s.qtimer <= 16'h0001) begin
                n.qtimer = s.upd;
                qfire    = 1'b1;
            end else begin
                n.qtimer = s.qtimer - 16'h0001;
            end
        end
        if (s.ctrl.qr_en && s.ctrl.shot) begin
            qfire = 1'b1;
        end
        if (qfire) begin
            n.tx_req = 1'b1;
        end

        // ------------------------------------------------------------
        // sequencer: one process data write per cycle
        // ------------------------------------------------------------
        case (s.phase)
            S_IDLE: begin
                if (s.clr_pend) begin
                    n.clr_pend = 1'b0;
                    n.phase    = S_CLR;
                    n.cidx     = 2'h0;
                    n.got      = 4'h0;
                    n.bad      = 1'b0;
                end else if (s.cnt_dirty) begin
                    n.cnt_dirty = 1'b0;
                    n.mw        = '{1'b1, s.addrs[15:8], s.rxcnt};
                end else if (s.txc_dirty) begin
                    // a completion in this very cycle keeps the byte dirty
                    n.txc_dirty = s.tx_req && tx_done_i && s.ctrl.txcnt_en;
                    n.mw        = '{1'b1, s.addrs[31:24], s.txcnt};
                end else if (s.stat_dirty) begin
                    // RL6 status byte write
                    n.stat_dirty = 1'b0;
                    n.mw         = '{1'b1, s.addrs[23:16], s.tstate};
                end else if (fr_ok) begin
                    // RL8 error flag
                    if (fr_err) begin
                        n.tstate[ST_DERR] = 1'b1;
                        n.irq[IRQ_DERR]   = 1'b1;
                    end
                    if (s.ctrl.cons_en) begin
                        // RL1 stage until complete and clean
                        n.stage[rx_i.idx] = rx_i.val;
                        n.got = (s.got | (4'h1 << rx_i.idx)) & ALL;
                        n.bad = s.bad | fr_err;
                        if (n.got == ALL) begin
                            n.got = 4'h0;
                            n.bad = 1'b0;
                            if (!(s.bad || fr_err)) begin
                                n.phase = S_COMMIT;
                                n.cidx  = 2'h0;
                            end
                        end
                    end else if (!fr_err) begin
                        // RL2 immediate update
                        n.mw   = '{1'b1, imm_addr, rx_i.val};
                        rx_evt = 1'b1;
                    end
                end
            end
            S_COMMIT: begin
                n.mw = '{1'b1, pd_at(s.addrs[7:0], s.cidx), s.stage[s.cidx]};
                if (s.cidx == LAST) begin
                    n.phase = S_IDLE;
                    rx_evt  = 1'b1;
                end else begin
                    n.cidx = s.cidx + 2'h1;
                end
            end
            S_CLR: begin
                n.mw = '{1'b1, pd_at(s.addrs[7:0], s.cidx), 8'h00};
                if (s.cidx == LAST) begin
                    n.phase = S_IDLE;
                end else begin
                    n.cidx = s.cidx + 2'h1;
                end
            end
            default: n.phase = S_IDLE;
        endcase

        // RL7 RL9 RL16 a good reception clears timeout and marks execution
        if (rx_evt) begin
            n.tstate[ST_TMO]  = 1'b0;
            n.tstate[ST_DERR] = 1'b0;
            n.tstate[ST_NEXE] = 1'b0;
            n.irq[IRQ_RX]     = 1'b1;
            n.timer           = tmo_eff;
            // a response ends the wait; the next query re-arms it
            n.armed           = !s.ctrl.qr_en && tmo_eff != 16'h0000;
            // RL5 RL17 reception counter wraps
            if (s.ctrl.rxcnt_en) begin
                n.rxcnt     = s.rxcnt + 8'h01;
                n.cnt_dirty = 1'b1;
            end
        end

        // RL2 no timeout without consistency check
        if (!s.ctrl.cons_en) begin
            n.armed = 1'b0;
        end
        // RL6 any change schedules a rewrite; set wins over the clear above
        if (s.ctrl.stat_en && n.tstate != s.tstate) begin
            n.stat_dirty = 1'b1;
        end
        n.rx_rdy = (n.phase == S_IDLE) && !n.clr_pend && !n.cnt_dirty
                && !n.txc_dirty && !n.stat_dirty;
        n.irq_o  = |(n.irq & n.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s        <= '0;
            s.ctrl   <= CTRL_RST;
            s.tmo    <= TMO_RST;
            s.upd    <= UPD_RST;
            s.addrs  <= ADDR_RST;
            s.chk    <= CHK_RST;
            s.tstate <= TSTATE_RST;
            s.phase  <= S_IDLE;
            s.rx_rdy <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign rx_rdy_o = s.rx_rdy;
    assign tx_req_o = s.tx_req;
    assign irq_o    = s.irq_o;
    assign tstate_o = s.tstate;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_CONS_WAIT: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        (s.phase == S_COMMIT && $past(s.phase) == S_IDLE)
        |-> $past(s.ctrl.cons_en) && $past(fr_ok) && !$past(fr_err))
        else $error("commit started without a complete clean set");

    AST_IMMED: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        (fr_ok && !fr_err && !s.ctrl.cons_en)
        |=> s.mw.we && s.mw.addr == $past(imm_addr) && s.mw.data == $past(rx_i.val))
        else $error("frame not written immediately");

    AST_TMO_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        $rose(s.tstate[ST_TMO]) |-> $past(s.ctrl.cons_en) && $past(s.tick))
        else $error("timeout raised without consistency check or tick");

    AST_TMO_FIRE: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
        (s.tick && s.armed && s.ctrl.cons_en && s.tmo != 16'h0000
         && s.timer <= 16'h0001 && s.phase == S_IDLE && !rx_i.vld)
        |=> s.tstate[ST_TMO] && s.irq[IRQ_TMO])
        else $error("timeout did not fire");

    AST_DERR: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
        (fr_ok && fr_err) |=> s.tstate[ST_DERR])
        else $error("data error not flagged");

    AST_RSV: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        s.tstate[7:3] == 5'h00 && !$rose(s.tstate[ST_NEXE]))
        else $error("reserved status bits set or not-executed raised again");

    AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
        $changed(s.rxcnt) |-> s.rxcnt == 8'($past(s.rxcnt) + 8'h01))
        else $error("reception counter did not step by one");

    AST_TXREQ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
        (s.tx_req && !tx_done_i) |=> s.tx_req)
        else $error("query request dropped before completion");

    AST_TXCNT: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
        (s.tx_req && tx_done_i && s.ctrl.txcnt_en)
        |=> s.txcnt == 8'($past(s.txcnt) + 8'h01) ##[1:12]
            (s.mw.we && s.mw.addr == s.addrs[31:24]))
        else $error("transmission counter not stepped or written");

    AST_STATWR: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        ($changed(s.tstate) && s.ctrl.stat_en)
        |-> ##[1:12] (s.mw.we && s.mw.addr == s.addrs[23:16]))
        else $error("status byte not rewritten after a change");

    AST_OFFCLR: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
        (s.clr_pend && s.phase == S_IDLE)
        |=> s.phase == S_CLR ##1 (s.mw.we && s.mw.data == 8'h00))
        else $error("offline clear not carried out");

endmodule : ccq_core

// ---- ccq_pd_mem.sv ----
// process data byte memory with registered read port
`timescale 1ns/10ps
module ccq_pd_mem
    import ccq_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire ccq_wr_t       wr_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic [7:0]         rdata_o
);

    logic [7:0] mem [2**AW];

    always_ff @(posedge clk_i) begin
        if (wr_i.we) begin
            mem[wr_i.addr[AW-1:0]] <= wr_i.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule : ccq_pd_mem

// ---- ccq_pkg.sv ----
// package: constants and carrier types of the can consume/query handler
package ccq_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] TMO_MIN_MS = 16'h000a;
    localparam logic [15:0] UPD_MIN_MS = 16'h0005;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] R_CTRL   = 8'h00;
    localparam logic [7:0] R_TMO    = 8'h04;
    localparam logic [7:0] R_UPD    = 8'h08;
    localparam logic [7:0] R_ADDR   = 8'h0c;
    localparam logic [7:0] R_CHK    = 8'h10;
    localparam logic [7:0] R_TSTATE = 8'h14;
    localparam logic [7:0] R_IRQ    = 8'h18;
    localparam logic [7:0] R_MASK   = 8'h1c;
    localparam logic [7:0] R_PDA    = 8'h20;
    localparam logic [7:0] R_PDD    = 8'h24;
    localparam logic [7:0] R_CNT    = 8'h28;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ST_TMO   = 0;
    localparam int ST_DERR  = 1;
    localparam int ST_NEXE  = 2;
    localparam int IRQ_RX   = 0;
    localparam int IRQ_TMO  = 1;
    localparam int IRQ_DERR = 2;
    localparam int IRQ_TX   = 3;
    localparam logic [15:0] TMO_RST    = 16'h0000;
    localparam logic [15:0] UPD_RST    = 16'h03e8;
    localparam logic [31:0] ADDR_RST   = 32'h1211_1000;
    localparam logic [23:0] CHK_RST    = 24'hff_0008;
    localparam logic [7:0]  TSTATE_RST = 8'h04;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic shot;
        logic txcnt_en;
        logic cyc_en;
        logic qr_en;
        logic stat_en;
        logic rxcnt_en;
        logic offl_clr;
        logic cons_en;
    } ccq_ctrl_t;
    localparam ccq_ctrl_t CTRL_RST = 8'h00;

    typedef struct packed {
        logic       vld;
        logic [1:0] idx;
        logic [3:0] len;
        logic [7:0] cbyte;
        logic [7:0] val;
    } ccq_frame_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } ccq_wr_t;

    typedef enum logic [1:0] {S_IDLE, S_COMMIT, S_CLR} ccq_phase_t;

    typedef struct packed {
        ccq_ctrl_t       ctrl;
        logic [15:0]     tmo;
        logic [15:0]     upd;
        logic [31:0]     addrs;
        logic [23:0]     chk;
        logic [7:0]      pda;
        logic [3:0]      irq;
        logic [3:0]      mask;
        logic            irq_o;
        logic            ack;
        logic [31:0]     rdat;
        logic [7:0]      tstate;
        logic            stat_dirty;
        logic            cnt_dirty;
        logic            txc_dirty;
        logic            clr_pend;
        logic [7:0]      rxcnt;
        logic [7:0]      txcnt;
        ccq_phase_t      phase;
        logic [1:0]      cidx;
        logic [3:0]      got;
        logic            bad;
        logic [3:0][7:0] stage;
        logic [15:0]     div;
        logic            tick;
        logic [15:0]     timer;
        logic            armed;
        logic [15:0]     qtimer;
        logic            tx_req;
        logic            offl_q;
        ccq_wr_t         mw;
        logic            rx_rdy;
    } ccq_state_t;

endpackage : ccq_pkg

// ---- testbench.sv ----
// self-checking bench for the can consume/query handler
`timescale 1ns/10ps
module testbench;
    import ccq_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, offline = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, r, wb_dat_o;
    logic        wb_ack_o, rx_rdy, tx_req, tx_done, irq;
    logic [7:0]  tstate;
    ccq_frame_t  rx;
    int          error_cnt = 0, check_count = 0;
    time         t0;

    always #50 clk_i = ~clk_i;

    ccq_core #(.TICK_CYC(10), .FRAMES(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx), .rx_rdy_o(rx_rdy),
        .offline_i(offline), .tx_req_o(tx_req), .tx_done_i(tx_done), .irq_o(irq),
        .tstate_o(tstate));
    ccq_can_node node (.clk_i(clk_i), .rst_i(rst_i), .tx_req_i(tx_req), .rx_rdy_i(rx_rdy),
        .rx_o(rx), .tx_done_o(tx_done));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        r = wb_dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd

    task automatic pd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b1, R_PDA, {24'h0, a});
        rd(R_PDD, {24'h0, e});
    endtask : pd

    task automatic wait_tx(input logic v);
        while (tx_req !== v) @(posedge clk_i);
    endtask : wait_tx

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(R_TSTATE, 32'h04);
        rd(R_UPD, 32'h3e8);
        rd(R_ADDR, ADDR_RST);
        rd(8'hfc, 32'h0);
        wb(1'b1, R_TMO, 32'h5);
        rd(R_TMO, 32'h0a);
        $display("reset test done");
    endtask : t_reset

    task automatic t_cons_off;
        wb(1'b1, R_CTRL, 32'h0c);
        node.send(2'd0, 4'h8, 8'h00, 8'h55);
        pd(8'h00, 8'h55);
        pd(8'h11, 8'h00);
        chk(tstate, 8'h00);
        rd(R_CNT, 32'h01);
        repeat (150) @(posedge clk_i);
        chk(tstate[0], 1'b0);
        for (int k = 0; k < 255; k++) node.send(2'd0, 4'h8, 8'h00, 8'h55);
        rd(R_CNT, 32'h00);
        $display("consume direct test done");
    endtask : t_cons_off

    task automatic t_cons_on;
        logic [7:0] bad [3][3] = '{'{8'h4, 8'h0, 8'h1}, '{8'h8, 8'h5, 8'h1}, '{8'h8, 8'h0, 8'h90}};
        wb(1'b1, R_CHK, 32'h80_0008);
        wb(1'b1, R_CTRL, 32'h0d);
        node.send(2'd0, 4'h8, 8'h00, 8'h11);
        pd(8'h00, 8'h55);
        node.send(2'd1, 4'h8, 8'h00, 8'h22);
        pd(8'h00, 8'h11);
        pd(8'h01, 8'h22);
        foreach (bad[k]) begin
            node.send(2'd0, bad[k][0][3:0], bad[k][1], bad[k][2]);
            node.send(2'd1, 4'h8, 8'h00, 8'h33);
            pd(8'h01, 8'h22);
            chk(tstate, 8'h02);
        end
        $display("consistency test done");
    endtask : t_cons_on

    task automatic t_query;
        wb(1'b1, R_MASK, 32'h2);
        wb(1'b1, R_CTRL, 32'hd1);
        // the request rises only after the write is acked
        wait_tx(1'b1);
        wait_tx(1'b0);
        wb(1'b0, R_CNT, 32'h0);
        chk(r[15:8], 8'h01);
        repeat (80) @(posedge clk_i);
        chk(tstate[0], 1'b0);
        repeat (40) @(posedge clk_i);
        chk(tstate, 8'h03);
        chk(irq, 1'b1);
        wb(1'b0, R_IRQ, 32'h0);
        chk(r[1], 1'b1);
        @(posedge clk_i);
        chk(irq, 1'b0);
        // update interval kept above the timeout
        wb(1'b1, R_UPD, 32'h14);
        node.dly = 30;
        wb(1'b1, R_CTRL, 32'h31);
        wait_tx(1'b1);
        t0 = $time;
        wait_tx(1'b0);
        node.send(2'd0, 4'h8, 8'h00, 8'h01);
        node.send(2'd1, 4'h8, 8'h00, 8'h02);
        wait_tx(1'b1);
        chk(($time - t0) / 100, 200);
        chk(tstate, 8'h00);
        wb(1'b1, R_CTRL, 32'h01);
        $display("query test done");
    endtask : t_query

    task automatic t_offline;
        pd(8'h00, 8'h01);
        @(posedge clk_i);
        offline <= 1'b1;
        // give a wrongful clear time to land before looking
        repeat (6) @(posedge clk_i);
        pd(8'h00, 8'h01);
        wb(1'b1, R_CTRL, 32'h03);
        offline <= 1'b0;
        @(posedge clk_i);
        offline <= 1'b1;
        repeat (6) @(posedge clk_i);
        pd(8'h00, 8'h00);
        pd(8'h01, 8'h00);
        $display("offline test done");
    endtask : t_offline

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_cons_off();
        t_cons_on();
        t_query();
        t_offline();
        give_verdict();
    end

    initial begin
        #5_000_000;
        error_cnt++;
        give_verdict();
    end
endmodule : testbench
